// ### aog_regs.svh
`ifndef AOG_REGS_SVH
`define AOG_REGS_SVH

// ==========================================================
// serial register map
`define AOG_ADDR_SWING 8'h01
`define AOG_ADDR_CTRL 8'h02
`define AOG_ADDR_GAIN_LO 8'h03
`define AOG_ADDR_GAIN_HI 8'h04
`define AOG_ADDR_STATUS 8'h05
`define AOG_ADDR_EOVR_THR 8'hc3

// ==========================================================
// reset values
`define AOG_SWING_RST 3'h0
`define AOG_CTRL_RST 8'h00
`define AOG_GAIN_RST 8'h00
`define AOG_EOVR_THR_RST 8'he0

// ==========================================================
// control and gain register fields
`define AOG_CTRL_NORMAL_OVR 0
`define AOG_CTRL_DIG_EN 1
`define AOG_CTRL_NS_AB 2
`define AOG_CTRL_NS_CD 4
`define AOG_GAIN_W 4
`define AOG_GAIN_MAX 4'hc

// ==========================================================
// serial frame: read flag, 8 address bits, 8 data bits
`define AOG_SPI_LAST 5'h10
`define AOG_SPI_ADDR_LAST 5'h08
`define AOG_SPI_SHIFT_LAST 5'h0f

// ==========================================================
// link pipeline, counted in link clock cycles
`define AOG_DATA_PIPE 11
`define AOG_EARLY_PIPE 6

// ==========================================================
// sample format and fine gain coefficients (q2.10, steps of 0.5 db)
`define AOG_SMP_MAX 14'h1fff
`define AOG_SMP_MIN 14'h2000
`define AOG_COEF_FRAC 10
`define AOG_GAIN_COEFS {12'h7fb, 12'h789, 12'h71d, 12'h6b7, 12'h657, 12'h5fc, 12'h5a6, \
    12'h556, 12'h509, 12'h4c1, 12'h47d, 12'h43d, 12'h400}

`endif

// ### aog_pkg.sv
package aog_pkg;

    typedef enum logic [1:0] {
        AOG_NS_OFF = 2'b00,
        AOG_NS_BAND90 = 2'b01,
        AOG_NS_BAND45X2 = 2'b10,
        AOG_NS_RSVD = 2'b11
    } aog_ns_mode_t;

    typedef logic signed [13:0] aog_sample_t;
    typedef logic [31:0] aog_cfg_word_t;

endpackage

// ### aog_adc_output.sv
`timescale 1ns/1ps
`include "aog_regs.svh"


module aog_adc_output
    import aog_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_sen_n,
    input wire logic spi_sclk,
    input wire logic spi_sdata,
    output logic spi_sdout,
    output logic [2:0] output_swing,
    input wire logic link_clk,
    input wire logic [3:0][13:0] conv_sample,
    input wire logic [3:0] conv_over,
    input wire logic [1:0] conv_high_resolution_flag,
    output logic [1:0][1:0] noise_shaping_mode,
    output logic [1:0] high_resolution_flag,
    output logic [1:0] out_clk_rise,
    output logic [1:0] out_clk_fall,
    output logic [1:0][12:0] data_lane_pos_rise,
    output logic [1:0][12:0] data_lane_pos_fall,
    output logic [1:0][12:0] data_lane_neg_rise,
    output logic [1:0][12:0] data_lane_neg_fall,
    output logic [1:0] lowest_lane_pos_rise,
    output logic [1:0] lowest_lane_pos_fall,
    output logic [1:0] lowest_lane_neg_rise,
    output logic [1:0] lowest_lane_neg_fall
);

    // ==========================================================
    // serial port pin synchronisers
    logic [2:0] sen_s_ff;
    logic [2:0] sck_s_ff;
    logic [2:0] sdi_s_ff;
    logic sen_q_ff;
    logic sck_q_ff;
    logic sdi_q_ff;

    always_ff @(posedge clk) begin
        sen_s_ff <= {sen_s_ff[1:0], spi_sen_n};
        sck_s_ff <= {sck_s_ff[1:0], spi_sclk};
        sdi_s_ff <= {sdi_s_ff[1:0], spi_sdata};
    end

    wire sen_agree = sen_s_ff[1] == sen_s_ff[2];
    wire sck_agree = sck_s_ff[1] == sck_s_ff[2];
    wire sdi_agree = sdi_s_ff[1] == sdi_s_ff[2];
    wire sck_rise = sck_agree & sck_s_ff[2] & ~sck_q_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sen_q_ff <= 1'b1;
            sck_q_ff <= 1'b0;
            sdi_q_ff <= 1'b0;
        end else begin
            sen_q_ff <= sen_agree ? sen_s_ff[2] : sen_q_ff;
            sck_q_ff <= sck_agree ? sck_s_ff[2] : sck_q_ff;
            sdi_q_ff <= sdi_agree ? sdi_s_ff[2] : sdi_q_ff;
        end
    end

    // ==========================================================
    // serial frame
    logic [4:0] bit_cnt_ff;
    logic [15:0] shreg_ff;
    logic [7:0] sdo_sr_ff;
    logic spi_sdout_ff;
    logic [2:0] output_swing_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] gain_lo_ff;
    logic [7:0] gain_hi_ff;
    logic [7:0] thr_ff;
    logic [7:0] rdata_w;

    wire [16:0] sh_next = {shreg_ff, sdi_q_ff};
    wire bit_take = sck_rise & ~sen_q_ff;
    wire addr_done = bit_take & (bit_cnt_ff == `AOG_SPI_ADDR_LAST);
    wire frame_done = bit_take & (bit_cnt_ff == `AOG_SPI_LAST);
    wire reg_wr = frame_done & ~sh_next[16];
    wire [7:0] wr_addr = sh_next[15:8];
    wire [7:0] wr_data = sh_next[7:0];
    wire [7:0] rd_addr = sh_next[7:0];
    wire rd_load = addr_done & sh_next[8];
    wire rd_shift = bit_take & (bit_cnt_ff > `AOG_SPI_ADDR_LAST) & (bit_cnt_ff <= `AOG_SPI_SHIFT_LAST);
    wire cfg_busy;

    assign rdata_w = (rd_addr == `AOG_ADDR_SWING) ? {5'h00, output_swing_ff} :
                     (rd_addr == `AOG_ADDR_CTRL) ? ctrl_ff :
                     (rd_addr == `AOG_ADDR_GAIN_LO) ? gain_lo_ff :
                     (rd_addr == `AOG_ADDR_GAIN_HI) ? gain_hi_ff :
                     (rd_addr == `AOG_ADDR_STATUS) ? {7'h00, cfg_busy} :
                     (rd_addr == `AOG_ADDR_EOVR_THR) ? thr_ff : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n || sen_q_ff) begin
            bit_cnt_ff <= 5'h00;
            shreg_ff <= 16'h0000;
        end else if (bit_take) begin
            bit_cnt_ff <= frame_done ? 5'h00 : bit_cnt_ff + 5'h01;
            shreg_ff <= sh_next[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || sen_q_ff) begin
            sdo_sr_ff <= 8'h00;
            spi_sdout_ff <= 1'b0;
        end else if (rd_load) begin
            spi_sdout_ff <= rdata_w[7];
            sdo_sr_ff <= {rdata_w[6:0], 1'b0};
        end else if (rd_shift) begin
            spi_sdout_ff <= sdo_sr_ff[7];
            sdo_sr_ff <= {sdo_sr_ff[6:0], 1'b0};
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_swing_ff <= `AOG_SWING_RST;
            ctrl_ff <= `AOG_CTRL_RST;
            gain_lo_ff <= `AOG_GAIN_RST;
            gain_hi_ff <= `AOG_GAIN_RST;
            thr_ff <= `AOG_EOVR_THR_RST;
        end else if (reg_wr) begin
            if (wr_addr == `AOG_ADDR_SWING) output_swing_ff <= wr_data[2:0];
            if (wr_addr == `AOG_ADDR_CTRL) ctrl_ff <= wr_data;
            if (wr_addr == `AOG_ADDR_GAIN_LO) gain_lo_ff <= wr_data;
            if (wr_addr == `AOG_ADDR_GAIN_HI) gain_hi_ff <= wr_data;
            if (wr_addr == `AOG_ADDR_EOVR_THR) thr_ff <= wr_data;
        end
    end

    a_swing_write: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && wr_addr == `AOG_ADDR_SWING) |=> (output_swing_ff == $past(wr_data[2:0])))
        else $error("swing field did not take the written value");

    // ==========================================================
    // configuration crossing to the link domain (toggle handshake)
    aog_cfg_word_t bundle_ff;
    logic req_ff;
    logic [2:0] ack_s_ff;
    logic ack_q_ff;

    wire aog_cfg_word_t live_cfg = {thr_ff, gain_hi_ff, gain_lo_ff, ctrl_ff};
    wire ack_agree = ack_s_ff[1] == ack_s_ff[2];
    assign cfg_busy = req_ff != ack_q_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bundle_ff <= {`AOG_EOVR_THR_RST, `AOG_GAIN_RST, `AOG_GAIN_RST, `AOG_CTRL_RST};
            req_ff <= 1'b0;
            ack_q_ff <= 1'b0;
        end else begin
            ack_q_ff <= ack_agree ? ack_s_ff[2] : ack_q_ff;
            if (!cfg_busy && bundle_ff != live_cfg) begin
                bundle_ff <= live_cfg;
                req_ff <= ~req_ff;
            end
        end
    end

    a_cfg_settles: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cfg_busy) |-> ##[1:80] !cfg_busy)
        else $error("configuration handshake did not complete");

    // ==========================================================
    // link domain reset and configuration capture
    logic [2:0] lrst_s_ff;
    logic lrst_n_ff;
    logic [2:0] req_s_ff;
    logic lack_ff;
    aog_cfg_word_t lcfg_ff;

    always_ff @(posedge link_clk) begin
        lrst_s_ff <= {lrst_s_ff[1:0], rst_n};
        req_s_ff <= {req_s_ff[1:0], req_ff};
    end

    // acknowledge comes back through three register-clock stages
    always_ff @(posedge clk) begin
        ack_s_ff <= {ack_s_ff[1:0], lack_ff};
    end

    wire lrst_agree = lrst_s_ff[1] == lrst_s_ff[2];
    wire req_agree = req_s_ff[1] == req_s_ff[2];

    always_ff @(posedge link_clk) begin
        lrst_n_ff <= lrst_agree ? lrst_s_ff[2] : lrst_n_ff;
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n_ff) begin
            lcfg_ff <= {`AOG_EOVR_THR_RST, `AOG_GAIN_RST, `AOG_GAIN_RST, `AOG_CTRL_RST};
            lack_ff <= 1'b0;
        end else if (req_agree && req_s_ff[2] != lack_ff) begin
            lcfg_ff <= bundle_ff;
            lack_ff <= req_s_ff[2];
        end
    end

    wire l_normal = lcfg_ff[`AOG_CTRL_NORMAL_OVR];
    wire l_dig_en = lcfg_ff[`AOG_CTRL_DIG_EN];
    wire [15:0] l_gains = lcfg_ff[23:8];
    wire [7:0] l_thr = lcfg_ff[31:24];

    // ==========================================================
    // per-channel gain, saturation and overrange detection
    wire [155:0] coef_tbl = `AOG_GAIN_COEFS;
    aog_sample_t res_c [4];
    logic satp_c [4];
    logic satn_c [4];
    logic early_c [4];
    logic [15:0] last_c [4];
    logic flag_c [4];

    for (genvar c = 0; c < 4; c++) begin : g_ch
        logic [15:0] pipe_ff [`AOG_DATA_PIPE];
        logic [`AOG_EARLY_PIPE-1:0] ear_ff;
        wire [3:0] gfield = l_gains[c*`AOG_GAIN_W +: `AOG_GAIN_W];
        wire [3:0] gidx = !l_dig_en ? 4'h0 :
                          (gfield > `AOG_GAIN_MAX) ? `AOG_GAIN_MAX : gfield;
        wire [11:0] coef = coef_tbl[12*gidx +: 12];
        wire aog_sample_t smp = conv_sample[c];
        wire signed [26:0] prod = smp * $signed({1'b0, coef});
        wire [16:0] scaled = prod[26:`AOG_COEF_FRAC];
        wire ovf = ~(&scaled[16:13] | ~|scaled[16:13]);
        wire [13:0] mag = smp[13] ? ~smp : smp;

        assign satp_c[c] = (conv_over[c] & ~smp[13]) | (ovf & ~scaled[16]);
        assign satn_c[c] = (conv_over[c] & smp[13]) | (ovf & scaled[16]);
        assign res_c[c] = satp_c[c] ? `AOG_SMP_MAX :
                          satn_c[c] ? `AOG_SMP_MIN : scaled[13:0];
        assign early_c[c] = conv_over[c] | (mag[12:5] >= l_thr);

        always_ff @(posedge link_clk) begin
            pipe_ff[0] <= {conv_high_resolution_flag[c/2], satp_c[c] | satn_c[c], res_c[c]};
            for (int k = 1; k < `AOG_DATA_PIPE; k++) begin
                pipe_ff[k] <= pipe_ff[k-1];
            end
        end

        always_ff @(posedge link_clk) begin
            if (!lrst_n_ff) begin
                ear_ff <= '0;
            end else begin
                ear_ff <= {ear_ff[`AOG_EARLY_PIPE-2:0], early_c[c]};
            end
        end

        assign last_c[c] = pipe_ff[`AOG_DATA_PIPE-1];
        assign flag_c[c] = l_normal ? last_c[c][14] : ear_ff[`AOG_EARLY_PIPE-1];
    end

    a_gain_off: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        (!l_dig_en && !conv_over[0]) |-> (res_c[0] == conv_sample[0]))
        else $error("gain applied while digital functions are disabled");

    // ==========================================================
    // lane assembly per channel pair
    logic [1:0][1:0] ns_mode_ff;
    logic [1:0] high_resolution_flag_ff;
    logic [1:0] oclk_r_ff;
    logic [1:0] oclk_f_ff;
    logic [1:0][12:0] dl_r_ff;
    logic [1:0][12:0] dl_f_ff;
    logic [1:0] low_r_ff;
    logic [1:0] low_f_ff;

    for (genvar p = 0; p < 2; p++) begin : g_pair
        wire [15:0] wr = last_c[2*p];
        wire [15:0] wf = last_c[2*p+1];
        wire [12:0] up_r = wr[15] ? wr[13:1] : {wr[13:3], 2'b00};
        wire [12:0] up_f = wf[15] ? wf[13:1] : {wf[13:3], 2'b00};
        wire lo_r = wr[15] ? wr[0] : flag_c[2*p];
        wire lo_f = wf[15] ? wf[0] : flag_c[2*p+1];
        wire [1:0] ns_raw = lcfg_ff[`AOG_CTRL_NS_AB + 2*p +: 2];
        wire aog_ns_mode_t ns_sel = aog_ns_mode_t'(ns_raw);

        always_ff @(posedge link_clk) begin
            if (!lrst_n_ff) begin
                ns_mode_ff[p] <= AOG_NS_OFF;
                high_resolution_flag_ff[p] <= 1'b0;
                oclk_r_ff[p] <= 1'b0;
                oclk_f_ff[p] <= 1'b0;
                dl_r_ff[p] <= 13'h0000;
                dl_f_ff[p] <= 13'h0000;
                low_r_ff[p] <= 1'b0;
                low_f_ff[p] <= 1'b0;
            end else begin
                ns_mode_ff[p] <= (ns_sel == AOG_NS_RSVD) ? AOG_NS_OFF : ns_sel;
                high_resolution_flag_ff[p] <= wr[15];
                oclk_r_ff[p] <= 1'b1;
                oclk_f_ff[p] <= 1'b0;
                dl_r_ff[p] <= up_r;
                dl_f_ff[p] <= up_f;
                low_r_ff[p] <= lo_r;
                low_f_ff[p] <= lo_f;
            end
        end
    end

    a_early_flag_delay: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        (!l_normal && early_c[0]) ##7 (!l_normal && !high_resolution_flag_ff[0]) |-> low_r_ff[0])
        else $error("early overrange flag not seven cycles after the condition");

    a_normal_flag_lat: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        (l_normal && satp_c[0]) ##12 (l_normal && !high_resolution_flag_ff[0]) |-> low_r_ff[0])
        else $error("normal overrange flag not aligned with data latency");

    a_sat_pos_code: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        (satp_c[0] && !conv_high_resolution_flag[0]) |-> ##12 (dl_r_ff[0][12:2] == 11'h3ff))
        else $error("positive overdrive code wrong");

    a_sat_neg_code: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        (satn_c[1] && !conv_high_resolution_flag[0]) |-> ##12 (dl_f_ff[0][12:2] == 11'h400))
        else $error("negative overdrive code wrong");

    a_high_resolution_flag_flag: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        conv_high_resolution_flag[1] |-> ##12 high_resolution_flag_ff[1])
        else $error("high resolution flag not aligned with 14-bit data");

    a_lsb_on_lane: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        conv_high_resolution_flag[1] |-> ##12 (low_r_ff[1] == $past(res_c[2][0], 12)))
        else $error("lowest lane does not carry the lsb in high resolution");

    a_lane_diff: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
        (l_normal && satn_c[1]) ##12 (l_normal && !high_resolution_flag_ff[0])
            |-> (lowest_lane_pos_fall[0] && !lowest_lane_neg_fall[0]))
        else $error("odd channel overrange missing from the lowest lane");

    // ==========================================================
    // outputs
    assign spi_sdout = spi_sdout_ff;
    assign output_swing = output_swing_ff;
    assign noise_shaping_mode = ns_mode_ff;
    assign high_resolution_flag = high_resolution_flag_ff;
    assign out_clk_rise = oclk_r_ff;
    assign out_clk_fall = oclk_f_ff;
    assign data_lane_pos_rise = dl_r_ff;
    assign data_lane_pos_fall = dl_f_ff;
    assign data_lane_neg_rise = ~dl_r_ff;
    assign data_lane_neg_fall = ~dl_f_ff;
    assign lowest_lane_pos_rise = low_r_ff;
    assign lowest_lane_pos_fall = low_f_ff;
    assign lowest_lane_neg_rise = ~low_r_ff;
    assign lowest_lane_neg_fall = ~low_f_ff;

endmodule

// ### aog_rx_model.sv
`timescale 1ns/1ps

// ==========================================================
// capture side: rejoins both ddr halves of each lane per pair
module aog_rx_model (
    input wire logic [1:0][12:0] lane_pos_rise,
    input wire logic [1:0][12:0] lane_pos_fall,
    input wire logic [1:0][12:0] lane_neg_rise,
    input wire logic [1:0][12:0] lane_neg_fall,
    input wire logic [1:0] low_pos_rise,
    input wire logic [1:0] low_pos_fall,
    input wire logic [1:0] low_neg_rise,
    input wire logic [1:0] low_neg_fall,
    output logic [1:0][13:0] rx_even,
    output logic [1:0][13:0] rx_odd,
    output logic rx_ok
);
    // rising half is the even channel, falling half the odd one
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            rx_even[p] = {lane_pos_rise[p], low_pos_rise[p]};
            rx_odd[p] = {lane_pos_fall[p], low_pos_fall[p]};
        end
    end

    // differential legs must always be complementary
    assign rx_ok = (lane_neg_rise === ~lane_pos_rise) && (lane_neg_fall === ~lane_pos_fall) &&
        (low_neg_rise === ~low_pos_rise) && (low_neg_fall === ~low_pos_fall);
endmodule

// ### aog_adc_output_tb_top.sv
`timescale 1ns/1ps
`include "aog_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module aog_adc_output_tb_top;
    logic clk, link_clk, rst_n, spi_sen_n, spi_sclk, spi_sdata, spi_sdout;
    logic [2:0] output_swing;
    logic [3:0][13:0] conv_sample;
    logic [3:0] conv_over;
    logic [1:0] conv_high_resolution_flag, high_resolution_flag, out_clk_rise, out_clk_fall;
    logic [1:0][1:0] noise_shaping_mode;
    logic [1:0][12:0] lane_pos_rise, lane_pos_fall, lane_neg_rise, lane_neg_fall;
    logic [1:0] low_pos_rise, low_pos_fall, low_neg_rise, low_neg_fall;
    logic [1:0][13:0] rx_even, rx_odd;
    logic rx_ok;
    int num_errors = 0;
    int num_checks = 0;

    aog_adc_output dut (.clk(clk), .rst_n(rst_n), .spi_sen_n(spi_sen_n), .spi_sclk(spi_sclk),
        .spi_sdata(spi_sdata), .spi_sdout(spi_sdout), .output_swing(output_swing), .link_clk(link_clk),
        .conv_sample(conv_sample), .conv_over(conv_over), .conv_high_resolution_flag(conv_high_resolution_flag),
        .noise_shaping_mode(noise_shaping_mode), .high_resolution_flag(high_resolution_flag),
        .out_clk_rise(out_clk_rise), .out_clk_fall(out_clk_fall), .data_lane_pos_rise(lane_pos_rise),
        .data_lane_pos_fall(lane_pos_fall), .data_lane_neg_rise(lane_neg_rise),
        .data_lane_neg_fall(lane_neg_fall), .lowest_lane_pos_rise(low_pos_rise),
        .lowest_lane_pos_fall(low_pos_fall), .lowest_lane_neg_rise(low_neg_rise),
        .lowest_lane_neg_fall(low_neg_fall));

    aog_rx_model rx (.lane_pos_rise(lane_pos_rise), .lane_pos_fall(lane_pos_fall),
        .lane_neg_rise(lane_neg_rise), .lane_neg_fall(lane_neg_fall), .low_pos_rise(low_pos_rise),
        .low_pos_fall(low_pos_fall), .low_neg_rise(low_neg_rise), .low_neg_fall(low_neg_fall),
        .rx_even(rx_even), .rx_odd(rx_odd), .rx_ok(rx_ok));

    // ==========================================================
    // clocks
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #32 link_clk = ~link_clk;
    end

    // ==========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic link_step(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask

    // one 17-bit frame; read bits come out after rises 9 to 16
    task automatic spi_xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wd,
        output logic [7:0] rdata);
        logic [16:0] frame;
        frame = {rd, addr, wd};
        rdata = 8'h00;
        spi_sen_n = 1'b0;
        tick(8);
        for (int i = 16; i >= 0; i--) begin
            spi_sdata = frame[i];
            tick(8);
            spi_sclk = 1'b1;
            tick(8);
            spi_sclk = 1'b0;
            tick(8);
            if (i >= 1 && i <= 8) rdata[i - 1] = spi_sdout;
        end
        spi_sen_n = 1'b1;
        tick(8);
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] wd);
        logic [7:0] unused;
        spi_xfer(1'b0, addr, wd, unused);
    endtask

    task automatic reg_rd(input logic [7:0] addr, output logic [7:0] v);
        spi_xfer(1'b1, addr, 8'h00, v);
    endtask

    // one-cycle condition on a channel, then back to the quiet level
    task automatic pulse(input int ch, input logic [13:0] s, input logic ov);
        link_step(1);
        conv_sample[ch] = s;
        conv_over[ch] = ov;
        link_step(1);
        conv_sample[ch] = 14'h0040;
        conv_over[ch] = 1'b0;
    endtask

    // flag must show on the lat-th cycle and not on the cycle before or after it
    task automatic ovr_lat(input int lat);
        pulse(0, 14'h0040, 1'b1);
        link_step(lat - 2);
        `CHK(rx_even[0][0], 1'b0)
        link_step(1);
        `CHK(rx_even[0][0], 1'b1)
        link_step(1);
        `CHK(rx_even[0][0], 1'b0)
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [7:0] addr_tab [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hc3, 8'h07};
        logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00};
        logic [7:0] v;
        foreach (addr_tab[k]) begin
            reg_rd(addr_tab[k], v);
            `CHK(v, rst_tab[k])
        end
        reg_wr(`AOG_ADDR_SWING, 8'h05);
        `CHK(output_swing, 3'h5)
        reg_rd(`AOG_ADDR_SWING, v);
        `CHK(v, 8'h05)
        reg_wr(8'h07, 8'hff);
        reg_rd(8'h07, v);
        `CHK(v, 8'h00)
        reg_wr(`AOG_ADDR_CTRL, 8'h24);
        tick(100);
        `CHK(noise_shaping_mode, 4'b1001)
        reg_wr(`AOG_ADDR_CTRL, 8'h0c);
        tick(100);
        `CHK(noise_shaping_mode[0], 2'b00)
        reg_wr(`AOG_ADDR_CTRL, 8'h00);
        tick(100);
    endtask

    task automatic t_early;
        ovr_lat(7);
        reg_wr(`AOG_ADDR_EOVR_THR, 8'h10);
        tick(100);
        pulse(0, 14'h01e0, 1'b0);
        link_step(6);
        `CHK(rx_even[0][0], 1'b0)
        pulse(0, 14'h0200, 1'b0);
        link_step(6);
        `CHK(rx_even[0][0], 1'b1)
        reg_wr(`AOG_ADDR_EOVR_THR, 8'he0);
        tick(100);
    endtask

    task automatic t_normal;
        reg_wr(`AOG_ADDR_CTRL, 8'h01);
        tick(100);
        ovr_lat(12);
        link_step(1);
        conv_sample[1] = 14'h3f00;
        conv_over[1:0] = 2'b11;
        link_step(1);
        conv_sample[1] = 14'h0040;
        conv_over[1:0] = 2'b00;
        link_step(11);
        `CHK(rx_even[0][13:3], 11'h3ff)
        `CHK(rx_odd[0][13:3], 11'h400)
        `CHK(rx_odd[0][0], 1'b1)
        reg_wr(`AOG_ADDR_CTRL, 8'h00);
        tick(100);
        ovr_lat(7);
    endtask

    task automatic t_high_resolution_flag;
        link_step(1);
        conv_sample[3:2] = {14'h2a5b, 14'h1235};
        conv_high_resolution_flag[1] = 1'b1;
        link_step(1);
        conv_sample[3:2] = {14'h0040, 14'h0040};
        conv_high_resolution_flag[1] = 1'b0;
        link_step(11);
        `CHK(rx_even[1], 14'h1235)
        `CHK(rx_odd[1], 14'h2a5b)
        `CHK(high_resolution_flag, 2'b10)
        `CHK(rx_ok, 1'b1)
        link_step(1);
        `CHK(rx_even[1], 14'h0040)
        `CHK(high_resolution_flag, 2'b00)
        `CHK({out_clk_rise, out_clk_fall}, 4'b1100)
    endtask

    // a sample of 400h makes the gained word equal the coefficient itself
    task automatic t_gain;
        logic [155:0] coefs;
        logic [13:0] exp_w;
        coefs = `AOG_GAIN_COEFS;
        conv_sample[1:0] = {14'h0400, 14'h0400};
        reg_wr(`AOG_ADDR_GAIN_LO, 8'h0c);
        tick(100);
        link_step(13);
        `CHK(rx_even[0][13:3], 11'h080)
        reg_wr(`AOG_ADDR_CTRL, 8'h02);
        for (int n = 0; n < 14; n++) begin
            reg_wr(`AOG_ADDR_GAIN_LO, 8'(n));
            tick(100);
            link_step(13);
            exp_w = 14'(coefs[12 * (n > 12 ? 12 : n) +: 12]);
            `CHK(rx_even[0][13:3], exp_w[13:3])
            `CHK(rx_odd[0][13:3], 11'h080)
        end
        `CHK(rx_ok, 1'b1)
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        rst_n = 1'b0;
        spi_sen_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdata = 1'b0;
        conv_sample = {4{14'h0040}};
        conv_over = 4'h0;
        conv_high_resolution_flag = 2'b00;
        // long enough for both the register and the link domain
        repeat (50) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick(10);
        t_regs;
        t_early;
        t_normal;
        t_high_resolution_flag;
        t_gain;
        wrap_up;
    end

    initial begin
        #400_000;
        num_errors++;
        wrap_up;
    end
endmodule
